// File: verif/acs_ctrl_sva.sv
// port assertions for the channel sequencer control block
// assumes one clk domain and the synchronous active-low rst_b of the design
`timescale 1ns/10ps
`default_nettype none
module acs_ctrl_sva
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        cs_b,
    input wire logic        conv_start,
    input wire logic        second_pair,
    input wire logic        conv_done,
    input wire logic        result_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // **********
    // checks
    // **********
    start_lat_a: assert property ($fell(cs_b) |-> ##[3:5] conv_start)
        else $error("no conversion start after chip select fall");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    pair_hold_a: assert property ($changed(second_pair) |-> conv_start)
        else $error("pair changed without a conversion start");
    result_lat_a: assert property (conv_done |-> ##[1:10] result_valid)
        else $error("result not flagged in time");
    result_pulse_a: assert property (result_valid |=> !result_valid)
        else $error("result flag longer than one cycle");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_b |=> !conv_start && !result_valid)
        else $error("activity right after reset");
    bad_addr_a: assert property (psel && penable && paddr[1:0] == 2'b00
        |-> pslverr == (paddr > 12'h00C))
        else $error("slave error does not match address map");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside a setup cycle");
endmodule
bind acs_ctrl acs_ctrl_sva acs_ctrl_sva_i (.clk, .rst_b, .psel, .penable, .paddr, .pslverr,
    .prdata, .cs_b, .conv_start, .second_pair, .conv_done, .result_valid);
`default_nettype wire

// File: verif/acs_host_model.sv
// host and analog core model: drops chip select, returns raw results
// assumes the bench pulses go; starts are spaced by GAP cycles of 10 ns
`timescale 1ns/10ps
`default_nettype none
module acs_host_model
#(
    parameter GAP = 200
)
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        go,
    input  wire logic [15:0] val,
    input  wire logic        conv_start,
    output var  logic        cs_b,
    output var  logic        conv_done,
    output wire logic [15:0] raw_a,
    output wire logic [15:0] raw_b,
    output wire logic        busy
);
    // **********
    // behaviour
    // **********
    logic [9:0] t;
    logic [2:0] d;
    // 200 cycles is 500 kSPS, also serving as the power-up hold with cs_b high
    assign busy  = t < GAP;
    // result lines only valid with conv_done, inverted otherwise
    assign raw_a = conv_done ? val : ~val;
    assign raw_b = ~raw_a;
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            t <= 10'h000;
            d <= 3'h0;
            cs_b <= 1'b1;
            conv_done <= 1'b0;
        end
        else
        begin
            d <= {d[1:0], conv_start};
            conv_done <= d[2];
            if (conv_start)
                cs_b <= 1'b1;
            if (!busy && go)
            begin
                cs_b <= 1'b0;
                t <= 10'h000;
            end
            else if (t != 10'h3FF)
                t <= t + 10'h001;
        end
    end
endmodule
`default_nettype wire

// File: verif/tb_acs_ctrl.sv
// self-checking bench for the channel sequencer control block
// assumes acs_host_model as host and analog core; APB driven here
`timescale 1ns/10ps
`default_nettype none
`include "acs_map.vh"
module tb_acs_ctrl;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [15:0] val = 16'h0, raw_a, raw_b, ha [8];
    logic        pready, pslverr, cs_b, conv_start, second_pair, conv_done, e, fill;
    logic        shift_bit = 1'b0, go = 1'b0, sdo_a, sdo_b, result_valid, busy;
    int          errors = 0, checks = 0;
    always #5 clk = ~clk;
    acs_ctrl acs_ctrl_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .cs_b, .conv_start, .second_pair, .conv_done, .raw_a, .raw_b,
        .shift_bit, .sdo_a, .sdo_b, .result_valid);
    acs_host_model acs_host_model_i (.clk, .rst_b, .go, .val, .conv_start, .cs_b, .conv_done,
        .raw_a, .raw_b, .busy);
    // **********
    // tasks
    // **********
    task end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x)
        begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task tmo(input int k);
        if (k >= 400)
        begin
            errors++;
            end_of_test();
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        tmo(k);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task reset;
        rst_b <= 1'b0;
        fill = 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    // n is the averaging count, 1 when averaging is off
    task conv(input logic [15:0] v, input logic p, input int n);
        int k, i;
        logic [31:0] sa, sb;
        for (i = 7; i >= 0; i--)
            ha[i] = (fill || i == 0) ? v : ha[i-1];
        fill = 1'b0;
        sa = 0;
        sb = 0;
        for (i = 0; i < n; i++)
        begin
            sa += {16'h0000, ha[i]};
            sb += {16'h0000, ~ha[i]};
        end
        sa = sa / n;
        sb = sb / n;
        val <= v;
        go <= 1'b1;
        k = 0;
        @(posedge clk);
        while (conv_start !== 1'b1 && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        tmo(k);
        go <= 1'b0;
        chk(second_pair, p);
        k = 0;
        while (result_valid !== 1'b1 && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        tmo(k);
        @(posedge clk);
        for (i = 15; i >= 0; i--)
        begin
            chk({sdo_a, sdo_b}, {sa[i], sb[i]});
            shift_bit <= 1'b1;
            @(posedge clk);
            shift_bit <= 1'b0;
            @(posedge clk);
        end
        apb(1'b0, `ACS_RESULT_A_ADDR, 32'h0);
        chk(q, sa);
        apb(1'b0, `ACS_RESULT_B_ADDR, 32'h0);
        chk(q, sb);
    endtask
    task s_regs;
        apb(1'b0, `ACS_SETUP_ADDR, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h0);
        chk({31'h0, pready}, 32'h1);
        apb(1'b1, `ACS_SETUP_ADDR, 32'hFFFFFFFF);
        apb(1'b0, `ACS_SETUP_ADDR, 32'h0);
        chk(q, 32'h3F);
        apb(1'b0, 12'h010, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask
    task s_manual;
        apb(1'b1, `ACS_SETUP_ADDR, 32'h0);
        conv(16'h8001, 1'b0, 1);
        apb(1'b1, `ACS_SETUP_ADDR, 32'h10);
        conv(16'h7FFE, 1'b1, 1);
    endtask
    task s_seq;
        apb(1'b1, `ACS_SETUP_ADDR, 32'h30);
        conv(16'h0011, 1'b0, 1);
        apb(1'b0, `ACS_STATUS_ADDR, 32'h0);
        chk(q, 32'h2);
        conv(16'h0022, 1'b1, 1);
        apb(1'b0, `ACS_STATUS_ADDR, 32'h0);
        chk(q, 32'h1);
        conv(16'h0033, 1'b0, 1);
        apb(1'b1, `ACS_SETUP_ADDR, 32'h10);
        conv(16'h0044, 1'b1, 1);
        apb(1'b1, `ACS_SETUP_ADDR, 32'h20);
        conv(16'h0055, 1'b0, 1);
    endtask
    task s_avg;
        int r;
        reset();
        apb(1'b1, `ACS_SETUP_ADDR, 32'h0);
        conv(16'h0064, 1'b0, 1);
        conv(16'hFFF0, 1'b0, 1);
        conv(16'h0007, 1'b0, 1);
        for (r = 1; r <= 3; r++)
        begin
            apb(1'b1, `ACS_SETUP_ADDR, 32'h8 | r);
            conv(16'h0D0D * r[15:0], 1'b0, 1 << r);
        end
        apb(1'b1, `ACS_SETUP_ADDR, 32'hC);
        conv(16'h0005, 1'b0, 1);
        apb(1'b1, `ACS_SETUP_ADDR, 32'h3);
        conv(16'h0009, 1'b0, 1);
    endtask
    initial
    begin
        reset();
        s_regs();
        s_manual();
        s_seq();
        s_avg();
        end_of_test();
    end
endmodule
`default_nettype wire

// File: verilog/acs_ctrl.v
// channel pair selection, two-step sequencer and rolling-average control with APB registers
// assumes the analog core pulses conv_done with both results on clk; cs_b is an async pin
//
// How it works
// - pair select clear, sequencer off: convert first inputs of both converters
// - pair select set, sequencer off: convert second inputs of both converters
// - sequencer enable bit turns automatic pair cycling off or on
// - while sequencing, the pair select bit is not consulted
// - sequence starts at first pair, then second, then wraps forever
// - averaging applies only with mode bit one and a valid nonzero ratio
// - mode zero and ratio zero give single unaveraged results
// - results are straight binary, shifted out most significant bit first
// - history holds eight results; every conversion enters it regardless of averaging
// - averaged output is sum of n newest results divided by n
`timescale 1ns/10ps
`default_nettype none
`include "acs_map.vh"

module acs_ctrl
(
    input  wire                      clk,
    input  wire                      rst_b,
    input  wire                      psel,
    input  wire                      penable,
    input  wire                      pwrite,
    input  wire [11:0]               paddr,
    input  wire [31:0]               pwdata,
    output wire                      pready,
    output wire                      pslverr,
    output reg  [31:0]               prdata,
    input  wire                      cs_b,
    output reg                       conv_start,
    output reg                       second_pair,
    input  wire                      conv_done,
    input  wire [`ACS_RES_W-1:0]     raw_a,
    input  wire [`ACS_RES_W-1:0]     raw_b,
    input  wire                      shift_bit,
    output wire                      sdo_a,
    output wire                      sdo_b,
    output reg                       result_valid
);

    localparam ST_IDLE = 2'd0;
    localparam ST_READ = 2'd1;
    localparam ST_ACC  = 2'd2;

    // ************************************************************
    // register bus
    // ************************************************************
    reg  [5:0]  setup;
    reg  [`ACS_RES_W-1:0] result_a;
    reg  [`ACS_RES_W-1:0] result_b;
    reg         seq_pos;
    wire        wr_acc = psel && penable && pwrite;
    wire        hit    = (paddr == `ACS_SETUP_ADDR) || (paddr == `ACS_STATUS_ADDR) ||
                         (paddr == `ACS_RESULT_A_ADDR) || (paddr == `ACS_RESULT_B_ADDR);

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    always @(posedge clk)
    begin
        if (!rst_b)
            setup <= `ACS_SETUP_RESET;
        else if (wr_acc && (paddr == `ACS_SETUP_ADDR))
            setup <= pwdata[5:0];
    end

    always @(posedge clk)
    begin
        if (!rst_b)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == `ACS_SETUP_ADDR)
                prdata <= {26'h0000000, setup};
            else if (paddr == `ACS_STATUS_ADDR)
                prdata <= {29'h00000000, result_valid, seq_pos, second_pair};
            else if (paddr == `ACS_RESULT_A_ADDR)
                prdata <= {16'h0000, result_a};
            else if (paddr == `ACS_RESULT_B_ADDR)
                prdata <= {16'h0000, result_b};
            else
                prdata <= 32'h00000000;
        end
    end

    wire [2:0] ratio      = setup[`ACS_RATIO_MSB:`ACS_RATIO_LSB];
    wire       avg_mode   = setup[`ACS_AVG_MODE_BIT];
    wire       pair_sel   = setup[`ACS_PAIR_SEL_BIT];
    wire       auto_cycle = setup[`ACS_AUTO_CYCLE_BIT];
    // codes above the largest ratio are not valid and leave averaging off
    wire       avg_on     = avg_mode && (ratio != `ACS_RATIO_OFF) &&
                            (ratio <= `ACS_RATIO_MAX);

    // ************************************************************
    // chip select synchroniser and sequencer
    // ************************************************************
    reg cs_meta;
    reg cs_sync;
    reg cs_prev;
    reg auto_prev;

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end
        else
        begin
            cs_meta <= cs_b;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    wire cs_fall = cs_prev && !cs_sync;

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            conv_start  <= 1'b0;
            second_pair <= 1'b0;
            seq_pos     <= 1'b0;
            auto_prev   <= 1'b0;
        end
        else
        begin
            auto_prev  <= auto_cycle;
            conv_start <= cs_fall;
            if (auto_cycle && !auto_prev)
                seq_pos <= 1'b0;
            if (cs_fall)
            begin
                if (auto_cycle)
                begin
                    // a start in the enabling cycle still uses the first pair
                    second_pair <= seq_pos && auto_prev;
                    seq_pos     <= !(seq_pos && auto_prev);
                end
                else
                    second_pair <= pair_sel;
            end
        end
    end

    // ************************************************************
    // history and rolling average
    // ************************************************************
    reg  [1:0]  state;
    reg         filled;
    reg  [`ACS_HIST_AW-1:0] wr_ptr;
    reg  [`ACS_HIST_AW-1:0] rd_addr;
    reg  [3:0]  left;
    reg  [1:0]  shift_n;
    reg  [18:0] sum_a;
    reg  [18:0] sum_b;
    wire [2*`ACS_RES_W-1:0] rd_data;

    acs_history_mem u_hist
    (
        .clk     (clk),
        .wr_en   (conv_done),
        .fill    (!filled),
        .wr_addr (wr_ptr),
        .wr_data ({raw_a, raw_b}),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    wire [18:0] add_a = sum_a + {3'b000, rd_data[31:16]};
    wire [18:0] add_b = sum_b + {3'b000, rd_data[15:0]};
    wire [18:0] div_a = add_a >> shift_n;
    wire [18:0] div_b = add_b >> shift_n;

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            state        <= ST_IDLE;
            filled       <= 1'b0;
            wr_ptr       <= 3'h0;
            rd_addr      <= 3'h0;
            left         <= 4'h0;
            shift_n      <= 2'h0;
            sum_a        <= 19'h00000;
            sum_b        <= 19'h00000;
            result_a     <= 16'h0000;
            result_b     <= 16'h0000;
            result_valid <= 1'b0;
        end
        else
        begin
            result_valid <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (conv_done)
                    begin
                        filled  <= 1'b1;
                        wr_ptr  <= wr_ptr + 3'h1;
                        rd_addr <= wr_ptr;
                        sum_a   <= 19'h00000;
                        sum_b   <= 19'h00000;
                        if (avg_on)
                        begin
                            shift_n <= ratio[1:0];
                            left    <= 4'h1 << ratio[1:0];
                            state   <= ST_READ;
                        end
                        else
                        begin
                            result_a     <= raw_a;
                            result_b     <= raw_b;
                            result_valid <= 1'b1;
                        end
                    end
                end
                ST_READ:
                begin
                    rd_addr <= rd_addr - 3'h1;
                    state   <= ST_ACC;
                end
                ST_ACC:
                begin
                    // one entry per cycle, newest first; read data trail by one
                    rd_addr <= rd_addr - 3'h1;
                    sum_a   <= add_a;
                    sum_b   <= add_b;
                    left    <= left - 4'h1;
                    if (left == 4'h1)
                    begin
                        result_a     <= div_a[15:0];
                        result_b     <= div_b[15:0];
                        result_valid <= 1'b1;
                        state        <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // serial presentation
    // ************************************************************
    reg [`ACS_RES_W-1:0] sh_a;
    reg [`ACS_RES_W-1:0] sh_b;

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            sh_a <= 16'h0000;
            sh_b <= 16'h0000;
        end
        else if (result_valid)
        begin
            sh_a <= result_a;
            sh_b <= result_b;
        end
        else if (shift_bit)
        begin
            sh_a <= {sh_a[14:0], 1'b0};
            sh_b <= {sh_b[14:0], 1'b0};
        end
    end

    assign sdo_a = sh_a[15];
    assign sdo_b = sh_b[15];

endmodule
`default_nettype wire

// File: verilog/acs_history_mem.v
// eight-entry history of conversion results, one write port, one registered read port
// assumes a single clock shared with the controller
`timescale 1ns/10ps
`default_nettype none
`include "acs_map.vh"

module acs_history_mem
(
    input  wire                          clk,
    input  wire                          wr_en,
    input  wire                          fill,
    input  wire [`ACS_HIST_AW-1:0]       wr_addr,
    input  wire [2*`ACS_RES_W-1:0]       wr_data,
    input  wire [`ACS_HIST_AW-1:0]       rd_addr,
    output reg  [2*`ACS_RES_W-1:0]       rd_data
);

    wire [2*`ACS_RES_W-1:0] word [0:`ACS_HIST_DEPTH-1];

    genvar i;
    generate
        for (i = 0; i < `ACS_HIST_DEPTH; i = i + 1)
        begin : g_entry
            // each entry has its own register so no word has two writers
            reg [2*`ACS_RES_W-1:0] entry;
            // fill writes every entry so averaging never sees stale data
            always @(posedge clk)
            begin
                if (wr_en && (fill || ({{(32-`ACS_HIST_AW){1'b0}}, wr_addr} == i)))
                    entry <= wr_data;
            end
            assign word[i] = entry;
        end
    endgenerate

    always @(posedge clk)
    begin
        rd_data <= word[rd_addr];
    end

endmodule
`default_nettype wire

// File: verilog/acs_map.vh
// register offsets, field positions and reset values of the channel sequencer control
// assumes APB with 32-bit data, one aligned word per register
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

`define ACS_SETUP_ADDR      12'h000
`define ACS_STATUS_ADDR     12'h004
`define ACS_RESULT_A_ADDR   12'h008
`define ACS_RESULT_B_ADDR   12'h00C

`define ACS_RATIO_LSB       0
`define ACS_RATIO_MSB       2
`define ACS_AVG_MODE_BIT    3
`define ACS_PAIR_SEL_BIT    4
`define ACS_AUTO_CYCLE_BIT  5
`define ACS_SETUP_RESET     6'h00

`define ACS_RATIO_OFF       3'h0
`define ACS_RATIO_MAX       3'h3
`define ACS_HIST_DEPTH      8
`define ACS_HIST_AW         3
`define ACS_RES_W           16

`endif
